//--- design/gsss_pkg.sv
package gsss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PRIME_HOLD_S = 3;
  localparam int unsigned VOLT_DELAY_S = 2;
  localparam int unsigned IDLE_SHORT_MIN = 5;
  localparam int unsigned IDLE_LONG_MIN = 15;
  localparam longint unsigned PRIME_HOLD_CYC = longint'(PRIME_HOLD_S) * CLK_HZ;
  localparam longint unsigned VOLT_DELAY_CYC = longint'(VOLT_DELAY_S) * CLK_HZ;
  localparam longint unsigned IDLE_SHORT_CYC =
    longint'(IDLE_SHORT_MIN) * 60 * CLK_HZ;
  localparam longint unsigned IDLE_LONG_CYC =
    longint'(IDLE_LONG_MIN) * 60 * CLK_HZ;
  localparam longint unsigned MINUTE_CYC = longint'(60) * CLK_HZ;
  localparam int unsigned CRANK_RPM = 1300;
  localparam int unsigned BLINK_HALF_CYC = 6_250_000;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GSSS_FUEL_INJECT,
    GSSS_FUEL_CARB,
    GSSS_FUEL_LPG
  } gsss_fuel_type;

  typedef struct packed {
    gsss_fuel_type fuel;
    logic isGasoline;
    logic longIdle;
  } gsss_cfg_type;

  // Actuator outputs travel together
  typedef struct packed {
    logic crank;
    logic fuelPump;
    logic injectEn;
    logic cutoffSol;
    logic chokeHeat;
    logic fieldFlash;
    logic ignKill;
    logic auxSupply;
    logic voltEn;
  } gsss_act_type;

  typedef struct packed {
    logic [15:0] crankCount;
    logic [15:0] runMinutes;
    logic [7:0] lastFault;
  } gsss_log_type;

  localparam logic [7:0] NO_FAULT = 8'h00;
  localparam logic [7:0] CFG_FAULT = 8'h01;
  localparam logic [11:0] FIELD_NOM = 12'h800;
  localparam logic [11:0] SAG_STEP = 12'h100;

endpackage

//--- design/gsss_field_reg.sv
`timescale 1ns/1ns
// Field current regulator: unit-step integrating trim around nominal, with
// setpoint sag during a load step so the engine can recover speed.
module gsss_field_reg #(
  parameter int W = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic [W-1:0] voltSense,
  input wire logic [W-1:0] voltNominal,
  input wire logic loadStep,
  output logic [W-1:0] fieldDuty_r,
  output logic sagActive_r
);
  logic [W-1:0] setpoint;
  logic [W-1:0] fieldDuty_nxt;

  assign setpoint = sagActive_r ? voltNominal - gsss_pkg::SAG_STEP
                                : voltNominal;

  // Unit-step integrator keeps it small and never wraps
  always_comb
  begin
    fieldDuty_nxt = fieldDuty_r;
    if (!enable)
      fieldDuty_nxt = '0;
    else if (voltSense < setpoint && fieldDuty_r != '1)
      fieldDuty_nxt = fieldDuty_r + 1'b1;
    else if (voltSense > setpoint && fieldDuty_r != '0)
      fieldDuty_nxt = fieldDuty_r - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      fieldDuty_r <= '0;
    else
      fieldDuty_r <= fieldDuty_nxt;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sagActive_r <= 1'b0;
    else
      sagActive_r <= enable && loadStep;
  end

  sag_follows_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (enable && loadStep) |=> sagActive_r)
    else $error("setpoint sag missing after load step");

endmodule // gsss_field_reg

//--- design/gsss_sequencer.sv
`timescale 1ns/1ns
module gsss_sequencer #(
  parameter longint unsigned PRIME_CYC = gsss_pkg::PRIME_HOLD_CYC,
  parameter longint unsigned VOLT_CYC = gsss_pkg::VOLT_DELAY_CYC,
  parameter longint unsigned IDLE_S_CYC = gsss_pkg::IDLE_SHORT_CYC,
  // Long idle follows the short one, so scaling the short one scales both
  parameter longint unsigned IDLE_L_CYC =
    IDLE_S_CYC * gsss_pkg::IDLE_LONG_MIN / gsss_pkg::IDLE_SHORT_MIN,
  parameter longint unsigned BLINK_CYC = gsss_pkg::BLINK_HALF_CYC,
  parameter longint unsigned MIN_CYC = gsss_pkg::MINUTE_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic startIn,
  input wire logic stopIn,
  input wire gsss_pkg::gsss_cfg_type cfg,
  input wire logic memCheckDone,
  input wire logic memCheckOk,
  input wire logic [15:0] engineRpm,
  input wire logic [11:0] voltSense,
  input wire logic loadStep,
  input wire logic logAck,
  output gsss_pkg::gsss_act_type act_r,
  output logic lamp_r,
  output logic ready_r,
  output logic logWrite_r,
  output gsss_pkg::gsss_log_type logData_r,
  output logic powerHold_r,
  output logic [11:0] fieldDuty_r
);
  typedef enum logic [2:0] {
    S_INIT, S_IDLE, S_CRANK, S_WAITV, S_RUN, S_LOG, S_OFF
  } gsss_state_type;

  gsss_state_type state_r;
  // Wide enough for the long idle timeout at full clock rate
  logic [39:0] timer_r;
  logic [31:0] primeCnt_r;
  logic [31:0] blink_r;
  logic [31:0] minCnt_r;
  logic stopEff;
  logic startEff;
  logic overSpeed;

  // ----------------------------------------------------------------
  // Command qualification
  // ----------------------------------------------------------------
  assign stopEff = stopIn;
  assign startEff = startIn && !stopIn;
  assign overSpeed = engineRpm > 16'(gsss_pkg::CRANK_RPM);

  function automatic logic fuelPath(input gsss_pkg::gsss_cfg_type c,
                                    input gsss_pkg::gsss_fuel_type p);
    fuelPath = c.fuel == p;
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_r <= S_INIT;
    else
      case (state_r)
        S_INIT:
          if (memCheckDone && memCheckOk && cfg.fuel != 2'h3)
            state_r <= S_IDLE;
        S_IDLE:
          if (startEff)
            state_r <= S_CRANK;
          else if (timer_r == 40'(cfg.longIdle ? IDLE_L_CYC : IDLE_S_CYC))
            state_r <= S_OFF;
        S_CRANK:
          if (stopEff || !startIn)
            state_r <= S_LOG;
          else if (overSpeed)
            state_r <= S_WAITV;
        S_WAITV:
          if (stopEff)
            state_r <= S_LOG;
          else if (timer_r == 40'(VOLT_CYC))
            state_r <= S_RUN;
        S_RUN:
          if (stopEff)
            state_r <= S_LOG;
        S_LOG:
          if (logAck)
            state_r <= S_IDLE;
        S_OFF:
          state_r <= S_OFF;
        default:
          state_r <= S_INIT;
      endcase
  end

  // Shared delay counter, cleared whenever the qualifying state ends
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      timer_r <= '0;
    else if (state_r == S_IDLE && !startEff)
      timer_r <= timer_r + 1'b1;
    else if (state_r == S_WAITV && !stopEff)
      timer_r <= timer_r + 1'b1;
    else
      timer_r <= '0;
  end

  // Own counter so a prime always needs a fresh, unbroken stop hold
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      primeCnt_r <= '0;
    else if (state_r != S_IDLE || !stopIn)
      primeCnt_r <= '0;
    else if (primeCnt_r <= 32'(PRIME_CYC))
      primeCnt_r <= primeCnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      blink_r <= '0;
    else if (state_r != S_CRANK || blink_r == 32'(BLINK_CYC - 1))
      blink_r <= '0;
    else
      blink_r <= blink_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Actuators
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      act_r <= '0;
    else
    begin
      act_r.crank <= state_r == S_CRANK && startEff && !overSpeed;
      act_r.fuelPump <= cfg.isGasoline && ((state_r == S_IDLE && stopIn
        && primeCnt_r > 32'(PRIME_CYC)) || ((state_r == S_CRANK
        || state_r == S_WAITV || state_r == S_RUN) && !stopEff));
      act_r.injectEn <= fuelPath(cfg, gsss_pkg::GSSS_FUEL_INJECT)
        && (state_r inside {S_CRANK, S_WAITV, S_RUN}) && !stopEff;
      act_r.cutoffSol <= !fuelPath(cfg, gsss_pkg::GSSS_FUEL_INJECT)
        && (state_r inside {S_CRANK, S_WAITV, S_RUN}) && !stopEff;
      act_r.chokeHeat <= fuelPath(cfg, gsss_pkg::GSSS_FUEL_CARB)
        && (state_r inside {S_CRANK, S_WAITV}) && !stopEff;
      act_r.fieldFlash <= (state_r inside {S_CRANK, S_WAITV})
        && act_r.cutoffSol | act_r.injectEn && !stopEff;
      act_r.ignKill <= !(state_r inside {S_CRANK, S_WAITV, S_RUN})
        || stopEff;
      act_r.auxSupply <= (state_r inside {S_WAITV, S_RUN})
        && !act_r.crank && !stopEff;
      act_r.voltEn <= state_r == S_RUN && !stopEff;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      lamp_r <= 1'b0;
    else if (stopEff || !(state_r inside {S_CRANK, S_WAITV, S_RUN}))
      lamp_r <= 1'b0;
    else if (state_r == S_CRANK)
    begin
      if (blink_r == 32'(BLINK_CYC - 1))
        lamp_r <= !lamp_r;
    end
    else
      lamp_r <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ready_r <= 1'b0;
    else
      ready_r <= state_r != S_INIT && state_r != S_OFF;
  end

  // ----------------------------------------------------------------
  // Session log
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      minCnt_r <= '0;
    else if (state_r != S_RUN || minCnt_r == 32'(MIN_CYC - 1))
      minCnt_r <= '0;
    else
      minCnt_r <= minCnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      logData_r <= '0;
    else
    begin
      if (state_r == S_IDLE && startEff)
        logData_r.crankCount <= logData_r.crankCount + 1'b1;
      if (state_r == S_RUN && minCnt_r == 32'(MIN_CYC - 1))
        logData_r.runMinutes <= logData_r.runMinutes + 1'b1;
      if (state_r == S_CRANK && !startIn && !stopIn)
        logData_r.lastFault <= gsss_pkg::CFG_FAULT;
    end
  end

  // Held until acknowledged so a slow store cannot miss it
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      logWrite_r <= 1'b0;
    else
      logWrite_r <= state_r == S_LOG && !logAck;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      powerHold_r <= 1'b1;
    else if (state_r == S_OFF)
      powerHold_r <= 1'b0;
  end

  gsss_field_reg #(.W(12)) u_field (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .enable(state_r == S_RUN && !stopEff),
    .voltSense(voltSense),
    .voltNominal(gsss_pkg::FIELD_NOM),
    .loadStep(loadStep),
    .fieldDuty_r(fieldDuty_r),
    .sagActive_r()
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_wins_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (startIn && stopIn) |=> !act_r.crank)
    else $error("crank asserted while stop held");
  stop_kill_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stopIn |=> act_r.ignKill && !act_r.voltEn && !lamp_r)
    else $error("stop did not shut down outputs");
  speed_cut_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    overSpeed |=> !act_r.crank)
    else $error("crank held above cut-out speed");
  init_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !memCheckOk && state_r == S_INIT |=> state_r == S_INIT)
    else $error("left init without memory check");
  volt_delay_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(act_r.voltEn) |-> $past(state_r, 2) == S_WAITV)
    else $error("voltage enabled without delay");
  flash_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    act_r.voltEn |=> !act_r.fieldFlash)
    else $error("field flash on with voltage enabled");
  aux_after_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    act_r.auxSupply |-> !act_r.crank)
    else $error("aux supply with starter engaged");
  prime_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (act_r.fuelPump && state_r == S_IDLE) |-> cfg.isGasoline)
    else $error("prime on non-gasoline set");
  log_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_r == S_LOG && !logAck) |=> logWrite_r)
    else $error("session log not written");

  run_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    act_r.voltEn);
  prime_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    act_r.fuelPump && state_r == S_IDLE);
  off_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    !powerHold_r);

endmodule // gsss_sequencer

//--- sim/gsss_engine_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Engine, memory self-test and log store seen from the controller
// ----------------------------------------------------------------
module gsss_engine_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire gsss_pkg::gsss_act_type act,
  input wire logic logWrite,
  input wire logic stall,
  output logic [15:0] engineRpm,
  output logic memCheckDone,
  output logic memCheckOk,
  output logic logAck,
  output logic [11:0] voltSense
);
  logic [3:0] boot_r;
  logic [1:0] ack_r;

  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      boot_r <= 4'h0;
    else if (boot_r != 4'hF)
      boot_r <= boot_r + 4'h1;

  assign memCheckDone = (boot_r == 4'hF);
  assign memCheckOk = memCheckDone;

  // A stalled engine never catches, so cranking can be aborted
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      engineRpm <= 16'h0000;
    else if (act.ignKill)
      engineRpm <= 16'h0000;
    else if (act.crank && !stall && engineRpm < 16'h0708)
      engineRpm <= engineRpm + 16'h0064;

  // Slow store: acknowledges after a few cycles of write request
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      ack_r <= 2'h0;
    else if (!logWrite)
      ack_r <= 2'h0;
    else if (ack_r != 2'h3)
      ack_r <= ack_r + 2'h1;

  assign logAck = logWrite && (ack_r == 2'h3);
  // Slightly below nominal so the regulator has work to do
  assign voltSense = act.voltEn ? 12'h7C0 : 12'h000;
endmodule // gsss_engine_model

//--- sim/test_genset_start_stop_sequencer.sv
`timescale 1ns/1ns
module test_genset_start_stop_sequencer;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic startIn = 1'b0;
  logic stopIn = 1'b0;
  logic loadStep = 1'b0;
  logic stall = 1'b0;
  gsss_pkg::gsss_cfg_type cfg = '{gsss_pkg::gsss_fuel_type'(2'h3), 1'b1, 1'b0};
  logic memCheckDone, memCheckOk, logAck, ready_r, lamp_r;
  logic logWrite_r, powerHold_r;
  logic [15:0] engineRpm;
  logic [11:0] voltSense, fieldDuty_r;
  gsss_pkg::gsss_act_type act_r;
  gsss_pkg::gsss_log_type logData_r;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] cranks = 16'h0000;

  always #20 ref_clk = ~ref_clk;

  gsss_sequencer #(.PRIME_CYC(20), .VOLT_CYC(30), .IDLE_S_CYC(400),
    .BLINK_CYC(4), .MIN_CYC(50)) u_gsss_sequencer (
    .ref_clk(ref_clk), .arst_n(arst_n), .startIn(startIn),
    .stopIn(stopIn), .cfg(cfg), .memCheckDone(memCheckDone),
    .memCheckOk(memCheckOk), .engineRpm(engineRpm),
    .voltSense(voltSense), .loadStep(loadStep), .logAck(logAck),
    .act_r(act_r), .lamp_r(lamp_r), .ready_r(ready_r),
    .logWrite_r(logWrite_r), .logData_r(logData_r),
    .powerHold_r(powerHold_r), .fieldDuty_r(fieldDuty_r));

  gsss_engine_model u_gsss_engine_model (
    .ref_clk(ref_clk), .arst_n(arst_n), .act(act_r),
    .logWrite(logWrite_r), .stall(stall), .engineRpm(engineRpm),
    .memCheckDone(memCheckDone), .memCheckOk(memCheckOk),
    .logAck(logAck), .voltSense(voltSense));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic doReset();
    @(posedge ref_clk) arst_n <= 1'b0;
    tick(16);
    chk({act_r, powerHold_r}, 10'h001);
    @(posedge ref_clk) arst_n <= 1'b1;
    tick(1);
    chk(ready_r, 1'b0);
  endtask

  task automatic logCheck(input logic [7:0] fault, input logic ran);
    int i;
    for (i = 0; i < 10 && logWrite_r !== 1'b1; i++) tick(1);
    chk(logData_r.crankCount, cranks);
    chk(logData_r.lastFault, fault);
    if (ran)
      chk(logData_r.runMinutes != 16'h0000, 1'b1);
    for (i = 0; i < 20 && logWrite_r === 1'b1; i++) tick(1);
    chk(logWrite_r, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic prime(input logic gas);
    @(posedge ref_clk)
    begin
      cfg <= '{gsss_pkg::GSSS_FUEL_CARB, gas, 1'b0};
      stopIn <= 1'b1;
    end
    tick(17);
    chk(act_r.fuelPump, 1'b0);
    tick(8);
    chk(act_r.fuelPump, gas);
    @(posedge ref_clk) stopIn <= 1'b0;
    tick(5);
  endtask

  task automatic bothPressed();
    @(posedge ref_clk)
    begin
      startIn <= 1'b1;
      stopIn <= 1'b1;
    end
    tick(12);
    chk(act_r.crank, 1'b0);
    @(posedge ref_clk)
    begin
      startIn <= 1'b0;
      stopIn <= 1'b0;
    end
    tick(2);
  endtask

  task automatic runSet(input gsss_pkg::gsss_fuel_type f, input logic trim);
    int i;
    int flips;
    logic last;
    logic gas;
    logic [11:0] d0;
    gas = (f != gsss_pkg::GSSS_FUEL_LPG);
    @(posedge ref_clk)
    begin
      cfg <= '{f, gas, 1'b0};
      startIn <= 1'b1;
    end
    cranks++;
    tick(3);
    chk({act_r.crank, act_r.fuelPump}, {1'b1, gas});
    chk({act_r.injectEn, act_r.cutoffSol, act_r.chokeHeat},
      {f == gsss_pkg::GSSS_FUEL_INJECT, f != gsss_pkg::GSSS_FUEL_INJECT,
      f == gsss_pkg::GSSS_FUEL_CARB});
    chk(act_r.fieldFlash, 1'b1);
    flips = 0;
    last = lamp_r;
    for (i = 0; i < 40 && act_r.crank === 1'b1; i++)
    begin
      tick(1);
      flips += (lamp_r !== last);
      last = lamp_r;
    end
    chk(flips > 1, 1'b1);
    tick(1);
    chk(engineRpm > 16'h0514, 1'b1);
    chk({act_r.crank, lamp_r}, 2'h1);
    chk(act_r.auxSupply, 1'b1);
    @(posedge ref_clk) startIn <= 1'b0;
    for (i = 0; i < 60 && act_r.voltEn !== 1'b1; i++) tick(1);
    chk(i >= 28 && i <= 33, 1'b1);
    tick(1);
    chk(act_r.fieldFlash, 1'b0);
    if (trim)
    begin
      tick(5);
      d0 = fieldDuty_r;
      @(posedge ref_clk) loadStep <= 1'b1;
      tick(6);
      chk(d0 != 12'h000, 1'b1);
      chk(fieldDuty_r < d0, 1'b1);
      @(posedge ref_clk) loadStep <= 1'b0;
      tick(50);
    end
    @(posedge ref_clk) stopIn <= 1'b1;
    tick(2);
    chk({act_r.voltEn, act_r.fuelPump, act_r.injectEn, act_r.cutoffSol,
      act_r.ignKill, lamp_r}, 6'h02);
    @(posedge ref_clk) stopIn <= 1'b0;
    logCheck(8'h00, trim);
  endtask

  task automatic abortCrank();
    @(posedge ref_clk)
    begin
      stall <= 1'b1;
      startIn <= 1'b1;
    end
    cranks++;
    tick(6);
    chk(act_r.crank, 1'b1);
    @(posedge ref_clk) startIn <= 1'b0;
    tick(3);
    chk(act_r.crank, 1'b0);
    logCheck(8'h01, 1'b0);
    @(posedge ref_clk) stall <= 1'b0;
  endtask

  // Reset brings the set back to init, then the idle timer runs out
  task automatic idleOff(input logic lng, input int exp);
    int i;
    @(posedge ref_clk) cfg <= '{gsss_pkg::GSSS_FUEL_INJECT, 1'b1, lng};
    doReset();
    for (i = 0; i < 1300 && powerHold_r === 1'b1; i++) tick(1);
    chk(i > exp && i < exp + 25, 1'b1);
  endtask

  initial
  begin
    doReset();
    tick(30);
    chk(ready_r, 1'b0);
    @(posedge ref_clk) cfg <= '{gsss_pkg::GSSS_FUEL_INJECT, 1'b1, 1'b0};
    tick(5);
    chk(ready_r, 1'b1);
    prime(1'b1);
    prime(1'b0);
    bothPressed();
    runSet(gsss_pkg::GSSS_FUEL_INJECT, 1'b0);
    runSet(gsss_pkg::GSSS_FUEL_CARB, 1'b0);
    runSet(gsss_pkg::GSSS_FUEL_LPG, 1'b1);
    abortCrank();
    idleOff(1'b0, 400);
    idleOff(1'b1, 1200);
    summarize();
  end
endmodule // test_genset_start_stop_sequencer
